/* hdl/aosf_core.sv */
// Purpose: Automatic operation status flags for up to three systems
// Assumes: Machine events come from logic on hclk, no synchroniser
// Notes:   Software acting as sequence controller writes commands and
//          reads flags over AHB-Lite; zero wait state, always OKAY
`timescale 1ns/1ps
`default_nettype none
`include "aosf_defines.svh"

// Function
// - Mode indication waits for all-axis smoothing zero
// - Run flag set by start, held until reset
// - Reset: rewind command, emergency stop, servo alarm
// - Flags encode reset, stopped, paused, executing
// - Block-end halt enters stopped state
// - Mid-block suspension enters paused state
// - Started set by start, cleared by stops
// - Single block clears started after block end
// - Pause on hold off or manual mode
// - Pause ignores machine lock and M/S/T work
// - Start falling edge resumes when hold released
// - Paused cleared by any reset condition
// - In-reset held about four seconds after power
// - In-reset held after rewind command release
// - In-reset held after emergency or alarm clears
// - Strobe in random feed mode sets feed flag
// - Feed flag cleared by feed end or rewind
// - Indexing flag set by rewind in memory
// - Provide motion-complete flag for M ordering
// - Motion done set at power-up, end, reset
// - No motion done on suspension; works under lock
// - Smoothing zero only when no axis delay
module aosf_core
	import aosf_pkg::*;
#(
	parameter int unsigned NSYS       = 3,
	parameter int unsigned NAXES      = 8,
	parameter int unsigned PWRUP_CYC  = `AOSF_PWRUP_CYC,
	parameter int unsigned RRW_CYC    = `AOSF_RRW_HOLD_CYC,
	parameter int unsigned ESTOP_CYC  = `AOSF_ESTOP_HOLD_CYC
) (
	input  wire logic                        hclk,
	input  wire logic                        hresetn,
	input  wire logic                        hsel,
	input  wire logic [31:0]                 haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic [31:0]                 hwdata,
	input  wire logic                        hready,
	output logic                             hreadyout,
	output logic                             hresp,
	output logic [31:0]                      hrdata,
	input  wire aosf_mach_t [NSYS-1:0]       mach_evt,
	input  wire logic [NSYS-1:0][NAXES-1:0]  axis_accel_pending,
	output var aosf_flags_t [NSYS-1:0]       sys_flags,
	output var aosf_mode_t [NSYS-1:0]        mode_indicated
);

	// Automatic modes are memory and manual data input
	function automatic logic is_auto(input aosf_mode_t m);
		is_auto = (m == AOSF_MODE_MEM) || (m == AOSF_MODE_MDI);
	endfunction

	// Larger of two counts
	function automatic logic [31:0] max32(input logic [31:0] a,
		input logic [31:0] b);
		max32 = (a > b) ? a : b;
	endfunction

	// Word address within the map, or invalid
	function automatic logic map_hit(input logic [31:0] a);
		map_hit = (a[31:8] == 24'h00_0000) && (a[7:0] < `AOSF_MAP_TOP)
			&& (a[1:0] == 2'h0) && (a[3:2] < 2'h2);
	endfunction

	localparam logic [31:0] PWRUP_LD = 32'(PWRUP_CYC);
	localparam logic [31:0] RRW_LD   = 32'(RRW_CYC);
	localparam logic [31:0] ESTOP_LD = 32'(ESTOP_CYC);

	aosf_plc_t   [NSYS-1:0] ctrl_r;
	aosf_flags_t [NSYS-1:0] flags_r;
	aosf_mode_t  [NSYS-1:0] mode_r;

	// Bus address phase capture
	logic        wr_pend_r;
	logic [31:0] wr_addr_r;
	logic [31:0] hrdata_r;
	wire         addr_ph  = hsel && htrans[1] && hready;
	wire         rd_take  = addr_ph && !hwrite;
	wire         wr_take  = addr_ph && hwrite;
	wire  [1:0]  rd_sys   = haddr[5:4];
	wire         rd_stat  = haddr[2];
	wire  [1:0]  wr_sys   = wr_addr_r[5:4];
	wire         wr_ctrl  = wr_pend_r && map_hit(wr_addr_r) && !wr_addr_r[2];
	wire         rd_fwd   = wr_ctrl && (wr_addr_r[7:0] == haddr[7:0]);
	logic [31:0] rd_word;

	// Read mux; a read right behind a write to the same control word sees hwdata
	always_comb begin
		rd_word = 32'h0000_0000;
		if (!map_hit(haddr) || (32'(rd_sys) >= NSYS)) begin
			rd_word = 32'h0000_0000;
		end else if (rd_stat) begin
			rd_word = {21'h00_0000, mode_r[rd_sys], flags_r[rd_sys]};
		end else if (rd_fwd) begin
			rd_word = {24'h00_0000, hwdata[7:0]};
		end else begin
			rd_word = {24'h00_0000, ctrl_r[rd_sys]};
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_r;
	assign sys_flags = flags_r;
	assign mode_indicated = mode_r;

	// Bus state: write address held into the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 32'h0000_0000;
			hrdata_r  <= 32'h0000_0000;
		end else begin
			wr_pend_r <= wr_take;
			if (wr_take) begin
				wr_addr_r <= haddr;
			end
			if (rd_take) begin
				hrdata_r <= rd_word;
			end
		end
	end

	for (genvar s = 0; s < NSYS; s++) begin : g_sys
		// Each system sees only its own commands and events
		aosf_plc_t   plc;
		aosf_mach_t  ev;
		aosf_state_t st_r;
		aosf_state_t st_nxt;
		logic        start_q_r;
		logic        strobe_q_r;
		logic        rrw_q_r;
		logic [31:0] hold_cnt_r;
		logic [31:0] hold_cnt_nxt;
		aosf_flags_t flags_nxt;
		assign plc = ctrl_r[s];
		assign ev  = mach_evt[s];

		wire smooth_zero = ~|axis_accel_pending[s];
		wire estop_cause = ev.estop || ev.servo_alarm;
		wire rst_cond    = plc.reset_rewind_cmd || estop_cause;
		wire auto_md     = is_auto(mode_r[s]);
		wire start_rise  = plc.auto_start_cmd && !start_q_r;
		wire start_fall  = !plc.auto_start_cmd && start_q_r;
		wire strobe_rise = plc.strobe && !strobe_q_r;
		wire rrw_rise    = plc.reset_rewind_cmd && !rrw_q_r;
		wire ctrl_wr     = wr_ctrl && (wr_sys == 2'(s));

		// Automatic state; reset condition overrides everything else
		always_comb begin
			st_nxt = st_r;
			if (rst_cond) begin
				st_nxt = AOSF_ST_RESET;
			end else begin
				case (st_r)
					AOSF_ST_RESET, AOSF_ST_STOPPED: begin
						if (start_rise && auto_md) begin
							st_nxt = AOSF_ST_EXEC;
						end
					end
					AOSF_ST_EXEC: begin
						// Pausing is not gated by machine lock or M/S/T work
						if (!plc.pause_hold_n || !auto_md) begin
							st_nxt = AOSF_ST_PAUSED;
						end else if (ev.program_end) begin
							st_nxt = AOSF_ST_STOPPED;
						end else if (ev.block_end && plc.single_block_select) begin
							st_nxt = AOSF_ST_STOPPED;
						end
					end
					AOSF_ST_PAUSED: begin
						if (start_fall && plc.pause_hold_n && auto_md) begin
							st_nxt = AOSF_ST_EXEC;
						end
					end
					default: st_nxt = AOSF_ST_RESET;
				endcase
			end
		end

		// Hold-off count reloads while a cause stands, runs down after
		always_comb begin
			hold_cnt_nxt = (hold_cnt_r != 32'h0000_0000) ?
				hold_cnt_r - 32'h0000_0001 : 32'h0000_0000;
			if (plc.reset_rewind_cmd) begin
				hold_cnt_nxt = max32(hold_cnt_nxt, RRW_LD);
			end
			if (estop_cause) begin
				hold_cnt_nxt = max32(hold_cnt_nxt, ESTOP_LD);
			end
		end

		// Flag values; hardware sets take priority over clears
		always_comb begin
			flags_nxt = flags_r[s];
			flags_nxt.auto_run_flag     = (st_nxt != AOSF_ST_RESET);
			flags_nxt.auto_started_flag = (st_nxt == AOSF_ST_EXEC);
			flags_nxt.auto_paused_flag  = (st_nxt == AOSF_ST_PAUSED);
			flags_nxt.in_reset_flag     = rst_cond
				|| (hold_cnt_nxt != 32'h0000_0000);
			flags_nxt.smoothing_zero_flag = smooth_zero;
			if (strobe_rise && (mode_r[s] == AOSF_MODE_RANDFEED)) begin
				flags_nxt.random_feed_active = 1'b1;
			end else if (ev.feed_end || plc.reset_rewind_cmd) begin
				flags_nxt.random_feed_active = 1'b0;
			end
			if (rrw_rise && (mode_r[s] == AOSF_MODE_MEM)) begin
				flags_nxt.program_indexing_flag = 1'b1;
			end else if (ev.index_end) begin
				flags_nxt.program_indexing_flag = 1'b0;
			end
			// A finished motion or a reset condition sets it, never a held one
			if (ev.motion_end || rst_cond) begin
				flags_nxt.motion_done_flag = 1'b1;
			end else if (ev.motion_start) begin
				flags_nxt.motion_done_flag = 1'b0;
			end
		end

		// Control word written by software
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				ctrl_r[s] <= aosf_plc_t'(`AOSF_CTRL_RST);
			end else if (ctrl_wr) begin
				ctrl_r[s] <= aosf_plc_t'(hwdata[7:0]);
			end
		end

		// Mode switches over only once no axis carries a delay
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				mode_r[s] <= AOSF_MODE_MEM;
			end else if (smooth_zero) begin
				mode_r[s] <= plc.mode;
			end
		end

		// Previous command levels; they reset to the idle levels of the
		// control word so that no false edge follows reset
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				start_q_r  <= 1'b0;
				strobe_q_r <= 1'b0;
				rrw_q_r    <= 1'b0;
			end else begin
				start_q_r  <= plc.auto_start_cmd;
				strobe_q_r <= plc.strobe;
				rrw_q_r    <= plc.reset_rewind_cmd;
			end
		end

		// Automatic operation state
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				st_r <= AOSF_ST_RESET;
			end else begin
				st_r <= st_nxt;
			end
		end

		// Hold-off count starts full, so in-reset stands after power-up
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				hold_cnt_r <= PWRUP_LD;
			end else begin
				hold_cnt_r <= hold_cnt_nxt;
			end
		end

		// Flags; motion done starts set, as after initialisation
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				flags_r[s] <= aosf_flags_t'(`AOSF_FLAGS_RST);
			end else begin
				flags_r[s] <= flags_nxt;
			end
		end
	end

endmodule // aosf_core

`default_nettype wire

/* hdl/aosf_defines.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 200 MHz system clock, 32-bit AHB-Lite register bus
// Notes:   Each system owns one control and one status word
`ifndef AOSF_DEFINES_SVH
`define AOSF_DEFINES_SVH

// Register map, one block of words per system
`define AOSF_CTRL_OFS       8'h00
`define AOSF_STAT_OFS       8'h04
`define AOSF_SYS_STRIDE     8'h10
`define AOSF_MAP_TOP        8'h30

// Control word fields
`define AOSF_CTRL_START_BIT 0
`define AOSF_CTRL_HOLDN_BIT 1
`define AOSF_CTRL_RRW_BIT   2
`define AOSF_CTRL_SBK_BIT   3
`define AOSF_CTRL_STRB_BIT  4
`define AOSF_CTRL_MODE_LSB  5
`define AOSF_CTRL_RST       8'h02

// Status word fields
`define AOSF_STAT_MODE_LSB  8
`define AOSF_FLAGS_RST      8'h48

// Timing, times in milliseconds, clock in kilohertz
`define AOSF_CLK_KHZ        200000
`define AOSF_PWRUP_MS       4000
`define AOSF_RRW_HOLD_MS    500
`define AOSF_ESTOP_HOLD_MS  1000
`define AOSF_PWRUP_CYC      (`AOSF_PWRUP_MS * `AOSF_CLK_KHZ)
`define AOSF_RRW_HOLD_CYC   (`AOSF_RRW_HOLD_MS * `AOSF_CLK_KHZ)
`define AOSF_ESTOP_HOLD_CYC (`AOSF_ESTOP_HOLD_MS * `AOSF_CLK_KHZ)

`endif

/* hdl/aosf_pkg.sv */
// Purpose: Types shared by the status flag block and its bench
// Assumes: Three systems at most
// Notes:   Struct layouts match the control and status words
package aosf_pkg;

	// Operating modes as software encodes them
	typedef enum logic [2:0] {
		AOSF_MODE_MEM,
		AOSF_MODE_MDI,
		AOSF_MODE_JOG,
		AOSF_MODE_HANDLE,
		AOSF_MODE_INCR,
		AOSF_MODE_RANDFEED,
		AOSF_MODE_REFRTN,
		AOSF_MODE_AUTOINIT
	} aosf_mode_t;

	// Automatic operation state
	typedef enum logic [1:0] {
		AOSF_ST_RESET,
		AOSF_ST_STOPPED,
		AOSF_ST_PAUSED,
		AOSF_ST_EXEC
	} aosf_state_t;

	// Controller commands, low byte of the control word
	typedef struct packed {
		aosf_mode_t mode;
		logic       strobe;
		logic       single_block_select;
		logic       reset_rewind_cmd;
		logic       pause_hold_n;
		logic       auto_start_cmd;
	} aosf_plc_t;

	// Events from the interpolator and servo side, same clock
	typedef struct packed {
		logic estop;
		logic servo_alarm;
		logic block_end;
		logic program_end;
		logic motion_start;
		logic motion_end;
		logic feed_end;
		logic index_end;
	} aosf_mach_t;

	// Flags, low byte of the status word
	typedef struct packed {
		logic smoothing_zero_flag;
		logic motion_done_flag;
		logic program_indexing_flag;
		logic random_feed_active;
		logic in_reset_flag;
		logic auto_paused_flag;
		logic auto_started_flag;
		logic auto_run_flag;
	} aosf_flags_t;

endpackage

/* verif/aosf_core_props.sv */
// Purpose: Checker on the flags of system 0
// Assumes: Hold-off counts of 8 cycles or more
// Notes:   Bound to the core from the bench top file
`timescale 1ns/1ps
`default_nettype none
module aosf_core_props
	import aosf_pkg::*;
#(
	parameter int unsigned NSYS  = 3,
	parameter int unsigned NAXES = 8
) (
	input wire logic                       hclk,
	input wire logic                       hresetn,
	input wire logic                       hsel,
	input wire logic [31:0]                haddr,
	input wire logic [1:0]                 htrans,
	input wire logic                       hwrite,
	input wire logic [2:0]                 hsize,
	input wire logic [31:0]                hwdata,
	input wire logic                       hready,
	input wire logic                       hreadyout,
	input wire logic                       hresp,
	input wire logic [31:0]                hrdata,
	input wire aosf_mach_t [NSYS-1:0]      mach_evt,
	input wire logic [NSYS-1:0][NAXES-1:0] axis_accel_pending,
	input wire aosf_flags_t [NSYS-1:0]     sys_flags,
	input wire aosf_mode_t [NSYS-1:0]      mode_indicated
);
	// Views of system 0 only, the others are copies
	wire aosf_flags_t f0    = sys_flags[0];
	wire aosf_mach_t  e0    = mach_evt[0];
	wire aosf_mode_t  m0    = mode_indicated[0];
	wire logic        busy0 = |axis_accel_pending[0];

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Zero wait states and an OKAY answer at all times
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	a_state_code: assert property (
		!(f0.auto_started_flag && f0.auto_paused_flag) &&
		(f0.auto_run_flag || !f0.auto_started_flag))
		else $error("run started paused in illegal mix");
	a_reset_clears: assert property (e0.estop |=>
		!(f0.auto_run_flag || f0.auto_paused_flag))
		else $error("stop did not clear run or paused");
	a_reset_hold: assert property (
		$fell(e0.estop) |-> f0.in_reset_flag [*8])
		else $error("reset flag dropped early");
	a_done_cause: assert property ($rose(f0.motion_done_flag) |->
		$past(e0.motion_end || e0.estop || e0.servo_alarm) ||
		f0.in_reset_flag)
		else $error("motion done without cause");
	a_mode_gate: assert property (busy0 ##1 busy0 |->
		$stable(m0))
		else $error("mode moved while axes delayed");
	// The edge that releases reset still finds the flops held in reset
	a_smooth_flag: assert property (hresetn |=>
		f0.smoothing_zero_flag == !$past(busy0))
		else $error("smoothing flag wrong");
	a_start_mode: assert property ($rose(f0.auto_started_flag) |->
		$past(m0) inside {AOSF_MODE_MEM, AOSF_MODE_MDI})
		else $error("start outside auto mode");
	a_feed_mode: assert property ($rose(f0.random_feed_active) |->
		$past(m0) == AOSF_MODE_RANDFEED)
		else $error("feed flag outside feed mode");
	a_index_mem: assert property (
		$rose(f0.program_indexing_flag) |-> $past(m0) == AOSF_MODE_MEM)
		else $error("indexing outside memory mode");
endmodule // aosf_core_props
`default_nettype wire

/* verif/aosf_core_tb.sv */
// Purpose: Bench driving the flag block over AHB-Lite
// Assumes: Short hold-off counts stand in for seconds
// Notes:   System 0 is exercised, system 1 must stay idle
`timescale 1ns/1ps
`default_nettype none
module aosf_core_tb;
	import aosf_pkg::*;
	logic             hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0]      haddr, hwdata, hrdata, rd;
	logic [1:0]       htrans;
	aosf_mach_t [2:0] mach_evt;
	logic [2:0][7:0]  axis_busy;
	int               n_fail, checks_done;

	aosf_core #(.PWRUP_CYC(40), .RRW_CYC(10), .ESTOP_CYC(20)) DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .mach_evt(mach_evt),
		.axis_accel_pending(axis_busy), .sys_flags(), .mode_indicated());
	aosf_mach_model u_mach (.hclk(hclk), .mach_evt(mach_evt),
		.axis_busy(axis_busy));

	// 200 MHz clock
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	task automatic results();
		$display("checks %0d errors %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Bounded wait for hready, a hang ends the run
	task automatic hwait();
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hready_low() && k < 50);
		if (hready_low()) begin
			n_fail++;
			results();
		end
	endtask
	function automatic bit hready_low();
		return hreadyout !== 1'b1;
	endfunction
	// One single word transfer, address then data phase
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		{hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
		hwait();
		htrans <= 2'h0;
		hwdata <= d;
		hwait();
		rd = hrdata;
		hsel <= 1'b0;
	endtask
	task automatic cmp(input logic [7:0] a, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error word %h expected %h seen %h", a, exp, seen);
		end
	endtask
	// Flags settle a cycle after the write lands, so wait first
	task automatic chk(input logic [7:0] a, input logic [31:0] exp);
		repeat (2) @(posedge hclk);
		xfer(1'b0, a, 32'h0);
		cmp(a, rd, exp);
	endtask

	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		n_fail = 0;
		checks_done = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		chk(8'h04, 32'hC8);
		chk(8'h00, 32'h02);
		chk(8'h30, 32'h00);
		repeat (40) @(posedge hclk);
		xfer(1'b1, 8'h04, 32'hFF);
		chk(8'h04, 32'hC0);
		xfer(1'b1, 8'h00, 32'h03);
		chk(8'h04, 32'hC3);
		xfer(1'b1, 8'h00, 32'h00);
		chk(8'h04, 32'hC5);
		xfer(1'b1, 8'h00, 32'h01);
		xfer(1'b1, 8'h00, 32'h00);
		chk(8'h04, 32'hC5);
		xfer(1'b1, 8'h00, 32'h03);
		xfer(1'b1, 8'h00, 32'h02);
		chk(8'h04, 32'hC3);
		u_mach.pulse(0, 4);
		chk(8'h04, 32'hC1);
		xfer(1'b1, 8'h00, 32'h03);
		xfer(1'b1, 8'h00, 32'h0A);
		chk(8'h04, 32'hC3);
		u_mach.pulse(0, 5);
		chk(8'h04, 32'hC1);
		u_mach.pulse(0, 3);
		chk(8'h04, 32'h81);
		u_mach.pulse(0, 2);
		chk(8'h04, 32'hC1);
		u_mach.pulse(0, 3);
		xfer(1'b1, 8'h00, 32'h06);
		chk(8'h04, 32'hE8);
		// Indexing ends only when the model says so, never on its own
		u_mach.pulse(0, 0);
		chk(8'h04, 32'hC8);
		xfer(1'b1, 8'h00, 32'h02);
		chk(8'h04, 32'hC8);
		repeat (12) @(posedge hclk);
		chk(8'h04, 32'hC0);
		// Servo alarm, then emergency stop
		for (int b = 6; b < 8; b++) begin
			xfer(1'b1, 8'h00, 32'h02);
			xfer(1'b1, 8'h00, 32'h03);
			chk(8'h04, 32'hC3);
			u_mach.level(0, b, 1'b1);
			chk(8'h04, 32'hC8);
			u_mach.level(0, b, 1'b0);
			chk(8'h04, 32'hC8);
			repeat (20) @(posedge hclk);
			chk(8'h04, 32'hC0);
		end
		xfer(1'b1, 8'h00, 32'h02);
		xfer(1'b1, 8'h00, 32'h03);
		xfer(1'b1, 8'h00, 32'h43);
		chk(8'h04, 32'h2C5);
		xfer(1'b1, 8'h00, 32'h46);
		chk(8'h04, 32'h2C8);
		u_mach.delay(0, 8'h81);
		xfer(1'b1, 8'h00, 32'h22);
		chk(8'h04, 32'h248);
		u_mach.delay(0, 8'h00);
		repeat (12) @(posedge hclk);
		chk(8'h04, 32'h1C0);
		xfer(1'b1, 8'h00, 32'hA2);
		xfer(1'b1, 8'h00, 32'hB2);
		chk(8'h04, 32'h5D0);
		u_mach.pulse(0, 1);
		chk(8'h04, 32'h5C0);
		xfer(1'b1, 8'h00, 32'hA2);
		xfer(1'b1, 8'h00, 32'hB2);
		chk(8'h04, 32'h5D0);
		xfer(1'b1, 8'h00, 32'hA6);
		chk(8'h04, 32'h5C8);
		chk(8'h14, 32'hC0);
		results();
	end
endmodule // aosf_core_tb

bind aosf_core aosf_core_props #(.NSYS(NSYS), .NAXES(NAXES)) u_props (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .mach_evt(mach_evt),
	.axis_accel_pending(axis_accel_pending), .sys_flags(sys_flags),
	.mode_indicated(mode_indicated));
`default_nettype wire

/* verif/aosf_mach_model.sv */
// Purpose: Interpolator and servo side of the flag block
// Assumes: Events on hclk, pulses one cycle long
// Notes:   Levels stay until the bench changes them
`timescale 1ns/1ps
`default_nettype none
module aosf_mach_model
	import aosf_pkg::*;
(
	input  wire logic            hclk,
	output var aosf_mach_t [2:0] mach_evt,
	output var logic [2:0][7:0]  axis_busy
);
	// Quiet machine from time zero
	initial begin
		mach_evt = '0;
		axis_busy = '0;
	end
	// One-cycle pulse, so a slow event cannot count twice
	task automatic pulse(input int s, input int b);
		@(posedge hclk);
		mach_evt[s][b] <= 1'b1;
		@(posedge hclk);
		mach_evt[s][b] <= 1'b0;
	endtask
	// Stop or alarm level
	task automatic level(input int s, input int b, input logic v);
		@(posedge hclk);
		mach_evt[s][b] <= v;
	endtask
	// Axes still carrying an acceleration delay
	task automatic delay(input int s, input logic [7:0] v);
		@(posedge hclk);
		axis_busy[s] <= v;
	endtask
endmodule // aosf_mach_model
`default_nettype wire
